// file: verilog/lrd_pkg.sv
`default_nettype none

package lrd_pkg;

    // Register byte offsets, word aligned
    localparam logic [7:0] LRD_CTRL_OFS  = 8'h00;
    localparam logic [7:0] LRD_PLT_OFS   = 8'h04;
    localparam logic [7:0] LRD_FLT_OFS   = 8'h08;
    localparam logic [7:0] LRD_PINT_OFS  = 8'h0C;
    localparam logic [7:0] LRD_FINT_OFS  = 8'h10;
    localparam logic [7:0] LRD_LORA_OFS  = 8'h14;
    localparam logic [7:0] LRD_LORB_OFS  = 8'h18;
    localparam logic [7:0] LRD_STAT_OFS  = 8'h1C;
    localparam logic [7:0] LRD_IRQ_OFS   = 8'h20;

    // Control register fields
    localparam int LRD_CTRL_EN_LSB    = 0;
    localparam int LRD_CTRL_SELA_LSB  = 4;
    localparam int LRD_CTRL_ROUTEA    = 6;
    localparam int LRD_CTRL_SELB_LSB  = 8;
    localparam int LRD_CTRL_ROUTEB    = 10;
    localparam logic [31:0] LRD_CTRL_MASK = 32'h0000_0773;

    // Interval register fields
    localparam int LRD_INT_X_LSB = 0;
    localparam int LRD_INT_Y_LSB = 8;

    // Status register fields
    localparam int LRD_STAT_PLOCK   = 0;
    localparam int LRD_STAT_FLOCK   = 1;
    localparam int LRD_STAT_LOR_LSB = 2;

    // Reset values
    localparam logic [31:0] LRD_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LRD_THR_RST  = 32'h0000_0000;
    localparam logic [4:0]  LRD_X_RST    = 5'h00;
    localparam logic [2:0]  LRD_Y_RST    = 3'h0;
    localparam logic [15:0] LRD_N_RST    = 16'hFFFF;

    // Widths and counts
    localparam int LRD_SAMPLE_W = 32;
    localparam int LRD_QCNT_W   = 21;
    localparam int LRD_NUM_REF  = 2;
    localparam int LRD_NUM_PINS = 4;
    localparam logic [2:0] LRD_HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        QUAL_HUNT   = 2'h1,
        QUAL_LOCKED = 2'h2
    } lrd_qual_type;

endpackage : lrd_pkg

`default_nettype wire

// file: verilog/lrd_lock_if.sv
`default_nettype none

interface lrd_lock_if;
    logic       tick;
    logic       cmp_ok;
    logic [4:0] lock_exp;
    logic [2:0] unlock_exp;
    logic       locked;

    modport ctrl (output tick, output cmp_ok, output lock_exp,
                  output unlock_exp, input locked);
    modport qual (input tick, input cmp_ok, input lock_exp,
                  input unlock_exp, output locked);
endinterface : lrd_lock_if

`default_nettype wire

// file: verilog/lrd_lock_qual.sv
`default_nettype none

module lrd_lock_qual
    import lrd_pkg::*;
(
    input  wire logic hclk,     // System clock
    input  wire logic hresetn,  // Async reset, active low
    lrd_lock_if.qual  lk        // Comparator in, lock flag out
);

    lrd_qual_type          state_r, state_nxt;
    logic                  run_r, run_nxt;
    logic [LRD_QCNT_W-1:0] cnt_r, cnt_nxt, cnt_run;
    logic [LRD_QCNT_W-1:0] lock_tgt, unl_tgt;
    logic                  locked_r;
    logic [3:0]            unl_sh;

    assign unl_sh   = {1'b0, lk.unlock_exp} + 4'h1;
    assign lock_tgt = LRD_QCNT_W'(1) << lk.lock_exp;
    assign unl_tgt  = LRD_QCNT_W'(1) << unl_sh;
    assign lk.locked = locked_r;

    // Run length of the current comparator state, saturating
    always_comb begin
        if (lk.cmp_ok != run_r) begin
            cnt_run = LRD_QCNT_W'(1);
        end else if (&cnt_r) begin
            cnt_run = cnt_r;
        end else begin
            cnt_run = cnt_r + LRD_QCNT_W'(1);
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        run_nxt   = run_r;
        if (lk.tick) begin
            run_nxt = lk.cmp_ok;
            cnt_nxt = cnt_run;
            case (state_r)
                QUAL_HUNT: begin
                    if (lk.cmp_ok && cnt_run >= lock_tgt) begin
                        state_nxt = QUAL_LOCKED;
                    end
                end
                QUAL_LOCKED: begin
                    if (!lk.cmp_ok && cnt_run >= unl_tgt) begin
                        state_nxt = QUAL_HUNT;
                        cnt_nxt   = '0;
                        run_nxt   = 1'b0;
                    end
                end
                default: begin
                    state_nxt = QUAL_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= QUAL_HUNT;
            cnt_r    <= '0;
            run_r    <= 1'b0;
            locked_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            run_r    <= run_nxt;
            locked_r <= (state_nxt == QUAL_LOCKED);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_lock_after_run;
        (!locked_r && lk.tick && lk.cmp_ok && cnt_run >= lock_tgt)
            |=> locked_r;
    endproperty
    a_lock_after_run: assert property (p_lock_after_run)
        else $error("lock not taken after full true run");

    property p_lock_cause;
        !locked_r ##1 locked_r |-> $past(lk.tick) && $past(lk.cmp_ok);
    endproperty
    a_lock_cause: assert property (p_lock_cause)
        else $error("lock rose without a true sample");

    property p_hold;
        (locked_r && !(lk.tick && !lk.cmp_ok)) |=> locked_r;
    endproperty
    a_hold: assert property (p_hold)
        else $error("lock dropped without a false sample");

    property p_unlock;
        (locked_r && lk.tick && !lk.cmp_ok && cnt_run >= unl_tgt)
            |=> !locked_r && cnt_r == '0;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock did not clear and restart");

    property p_restart;
        (lk.tick && lk.cmp_ok != run_r && state_r == QUAL_HUNT)
            |=> cnt_r == LRD_QCNT_W'(1);
    endproperty
    a_restart: assert property (p_restart)
        else $error("run count not restarted on change");

endmodule : lrd_lock_qual

`default_nettype wire

// file: verilog/lrd_top.sv
// Chosen here: the AHB-Lite slave port and the register offsets.
`default_nettype none

module lrd_top
    import lrd_pkg::*;
(
    input  wire logic        hclk,                     // System clock
    input  wire logic        hresetn,                  // Async reset, low
    input  wire logic        hsel,                     // Slave select
    input  wire logic [31:0] haddr,                    // Byte address
    input  wire logic [1:0]  htrans,                   // Transfer type
    input  wire logic        hwrite,                   // Write when high
    input  wire logic [2:0]  hsize,                    // Transfer size
    input  wire logic [31:0] hwdata,                   // Write data
    input  wire logic        hready,                   // Bus ready
    output logic      [31:0] hrdata,                   // Read data
    output logic             hreadyout,                // Slave ready
    output logic             hresp,                    // Always OKAY
    input  wire logic        pdiv_tick,                // P-divider pulse
    input  wire logic [31:0] phase_sample,             // Detector sample
    input  wire logic        first_reference_input,    // Reference pin A
    input  wire logic        second_reference_input,   // Reference pin B
    output logic      [3:0]  multipurpose_status_pins, // Status pins
    output logic             phase_lock,               // Phase locked
    output logic             frequency_lock            // Frequency locked
);

    lrd_lock_if pl_if ();
    lrd_lock_if fl_if ();

    logic [31:0] ctrl_r;
    logic [31:0] plt_r;
    logic [31:0] flt_r;
    logic [4:0]  pl_x_r, fl_x_r;
    logic [2:0]  pl_y_r, fl_y_r;
    logic [15:0] lora_n_r, lorb_n_r;
    logic [LRD_NUM_REF-1:0] irq_r, irq_nxt, irq_clr;

    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        rd_pend_r;
    logic [7:0]  rd_addr_r;
    logic        hreadyout_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;
    logic        accept;
    logic        wr_en;

    logic signed [LRD_SAMPLE_W+1:0] samp_ext, prev_ext, diff;
    logic [LRD_SAMPLE_W-1:0] prev_r;
    logic [LRD_SAMPLE_W+1:0] phase_mag, diff_mag;

    logic [LRD_NUM_REF-1:0] ref_pin, ref_s1_r, ref_s2_r, ref_s3_r;
    logic [LRD_NUM_REF-1:0] ref_rise;
    logic [LRD_NUM_REF-1:0] lor_en;
    logic [LRD_NUM_REF-1:0] lor_lost;
    logic [LRD_NUM_REF-1:0] lor_set;
    logic [LRD_NUM_REF-1:0][15:0] lor_n;
    logic [LRD_NUM_REF-1:0][1:0]  pin_sel;
    logic [LRD_NUM_REF-1:0]       pin_route;
    logic        half_r;
    logic [LRD_NUM_PINS-1:0] pins_r;

    // Bus slave. Only word writes are taken; the address is decoded
    // on its low byte, so the map repeats across the upper bits.
    assign accept = hsel && htrans[1] && hready;
    assign wr_en  = wr_pend_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_pend_r <= 1'b0;
            rd_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite && (hsize == LRD_HSIZE_WORD);
            rd_pend_r <= accept && !hwrite;
            if (accept) begin
                wr_addr_r <= haddr[7:0];
                rd_addr_r <= haddr[7:0];
            end
        end
    end

    // Reads take one wait state so that a read right after a write
    // always returns the freshly written value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            hreadyout_r <= !(accept && !hwrite);
            if (rd_pend_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (rd_addr_r)
            LRD_CTRL_OFS: rd_mux = ctrl_r;
            LRD_PLT_OFS:  rd_mux = plt_r;
            LRD_FLT_OFS:  rd_mux = flt_r;
            LRD_PINT_OFS: rd_mux = {21'h0, pl_y_r, 3'h0, pl_x_r};
            LRD_FINT_OFS: rd_mux = {21'h0, fl_y_r, 3'h0, fl_x_r};
            LRD_LORA_OFS: rd_mux = {16'h0000, lora_n_r};
            LRD_LORB_OFS: rd_mux = {16'h0000, lorb_n_r};
            LRD_STAT_OFS: rd_mux = {28'h0, lor_lost,
                                    fl_if.locked, pl_if.locked};
            LRD_IRQ_OFS:  rd_mux = {30'h0, irq_r};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r   <= LRD_CTRL_RST;
            plt_r    <= LRD_THR_RST;
            flt_r    <= LRD_THR_RST;
            pl_x_r   <= LRD_X_RST;
            pl_y_r   <= LRD_Y_RST;
            fl_x_r   <= LRD_X_RST;
            fl_y_r   <= LRD_Y_RST;
            lora_n_r <= LRD_N_RST;
            lorb_n_r <= LRD_N_RST;
        end else if (wr_en) begin
            case (wr_addr_r)
                LRD_CTRL_OFS: ctrl_r <= hwdata & LRD_CTRL_MASK;
                LRD_PLT_OFS:  plt_r  <= hwdata;
                LRD_FLT_OFS:  flt_r  <= hwdata;
                LRD_PINT_OFS: begin
                    pl_x_r <= hwdata[LRD_INT_X_LSB +: 5];
                    pl_y_r <= hwdata[LRD_INT_Y_LSB +: 3];
                end
                LRD_FINT_OFS: begin
                    fl_x_r <= hwdata[LRD_INT_X_LSB +: 5];
                    fl_y_r <= hwdata[LRD_INT_Y_LSB +: 3];
                end
                LRD_LORA_OFS: lora_n_r <= hwdata[15:0];
                LRD_LORB_OFS: lorb_n_r <= hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // Write one to clear; a loss arriving in the same cycle wins
    assign irq_clr = (wr_en && wr_addr_r == LRD_IRQ_OFS) ?
                     hwdata[LRD_NUM_REF-1:0] : '0;
    assign irq_nxt = (irq_r & ~irq_clr) | lor_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= '0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // Lock detectors. The first difference after reset is taken
    // against zero and may be large; it only delays frequency lock.
    assign samp_ext  = {{2{phase_sample[31]}}, phase_sample};
    assign prev_ext  = {{2{prev_r[31]}}, prev_r};
    assign diff      = samp_ext - prev_ext;
    assign phase_mag = samp_ext[LRD_SAMPLE_W+1] ? -samp_ext : samp_ext;
    assign diff_mag  = diff[LRD_SAMPLE_W+1] ? -diff : diff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= '0;
        end else if (pdiv_tick) begin
            prev_r <= phase_sample;
        end
    end

    assign pl_if.tick       = pdiv_tick;
    assign pl_if.cmp_ok     = phase_mag <= {2'b00, plt_r};
    assign pl_if.lock_exp   = pl_x_r;
    assign pl_if.unlock_exp = pl_y_r;
    assign fl_if.tick       = pdiv_tick;
    assign fl_if.cmp_ok     = diff_mag <= {2'b00, flt_r};
    assign fl_if.lock_exp   = fl_x_r;
    assign fl_if.unlock_exp = fl_y_r;

    lrd_lock_qual u_phase_qual (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lk      (pl_if)
    );

    lrd_lock_qual u_freq_qual (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lk      (fl_if)
    );

    assign phase_lock     = pl_if.locked;
    assign frequency_lock = fl_if.locked;

    // Reference loss monitors
    assign ref_pin   = {second_reference_input, first_reference_input};
    assign lor_en    = ctrl_r[LRD_CTRL_EN_LSB +: LRD_NUM_REF];
    assign lor_n     = {lorb_n_r, lora_n_r};
    assign pin_sel   = {ctrl_r[LRD_CTRL_SELB_LSB +: 2],
                        ctrl_r[LRD_CTRL_SELA_LSB +: 2]};
    assign pin_route = {ctrl_r[LRD_CTRL_ROUTEB], ctrl_r[LRD_CTRL_ROUTEA]};
    assign ref_rise  = ref_s2_r & ~ref_s3_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_s1_r <= '0;
            ref_s2_r <= '0;
            ref_s3_r <= '0;
            half_r   <= 1'b0;
        end else begin
            ref_s1_r <= ref_pin;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            half_r   <= !half_r;
        end
    end

    generate
        for (genvar i = 0; i < LRD_NUM_REF; i++) begin : g_lor
            logic [15:0] cnt_r, cnt_nxt;
            logic        lost_r, lost_nxt;
            logic        inc;

            // Counting stops at N, so the flag stays up until an edge or until the monitor is disabled
            assign inc = lor_en[i] && !ref_rise[i] && half_r &&
                         (cnt_r != lor_n[i]);

            always_comb begin
                cnt_nxt  = cnt_r;
                lost_nxt = lost_r;
                if (!lor_en[i]) begin
                    cnt_nxt  = 16'h0000;
                    lost_nxt = 1'b0;
                end else if (ref_rise[i]) begin
                    cnt_nxt  = 16'h0000;
                    lost_nxt = 1'b0;
                end else if (inc) begin
                    cnt_nxt  = cnt_r + 16'h0001;
                    lost_nxt = (cnt_nxt == lor_n[i]);
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_r  <= 16'h0000;
                    lost_r <= 1'b0;
                end else begin
                    cnt_r  <= cnt_nxt;
                    lost_r <= lost_nxt;
                end
            end

            assign lor_lost[i] = lost_r;
            assign lor_set[i]  = lost_nxt && !lost_r;
        end
    endgenerate

    generate
        for (genvar p = 0; p < LRD_NUM_PINS; p++) begin : g_pin
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pins_r[p] <= 1'b0;
                end else begin
                    pins_r[p] <=
                        (pin_route[0] && pin_sel[0] == 2'(p) &&
                         lor_lost[0]) ||
                        (pin_route[1] && pin_sel[1] == 2'(p) &&
                         lor_lost[1]);
                end
            end
        end
    endgenerate

    assign multipurpose_status_pins = pins_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_phase_window;
        pl_if.cmp_ok == ($signed(samp_ext) <= $signed({2'b00, plt_r}) &&
                         $signed(samp_ext) >= -$signed({2'b00, plt_r}));
    endproperty
    a_phase_window: assert property (p_phase_window)
        else $error("phase compare disagrees with threshold window");

    property p_lor_full;
        (lor_en[0] && g_lor[0].cnt_r == lor_n[0]) |-> lor_lost[0];
    endproperty
    a_lor_full: assert property (p_lor_full)
        else $error("full watchdog count without loss flag");

    property p_lor_edge;
        ref_rise[1] |=> !lor_lost[1] && g_lor[1].cnt_r == 16'h0000;
    endproperty
    a_lor_edge: assert property (p_lor_edge)
        else $error("reference edge did not restart watchdog");

    property p_lor_off;
        !lor_en[0] |=> !lor_lost[0] && !lor_set[0];
    endproperty
    a_lor_off: assert property (p_lor_off)
        else $error("loss flag set while monitor disabled");

    property p_half_rate;
        g_lor[0].inc |=> !g_lor[0].inc;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("watchdog advanced on two cycles in a row");

    property p_irq_set;
        $rose(lor_lost[1]) |-> irq_r[1];
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("loss did not set interrupt status");

    property p_pin_route;
        (pin_route[0] && pin_sel[0] == 2'h2 && lor_lost[0])
            |=> multipurpose_status_pins[2];
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("routed loss flag missing on status pin");

    property p_read_wait;
        (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state not one cycle");

endmodule : lrd_top

`default_nettype wire

// file: verification/lrd_far_side.sv
`default_nettype none

module lrd_far_side (
    input  wire logic        hclk,         // System clock
    input  wire logic        tick_on,      // Run P-divider pulses
    input  wire logic [31:0] sample_in,    // Next detector value
    input  wire logic [3:0]  half_a,       // Ref A half period, 0 stops
    input  wire logic [3:0]  half_b,       // Ref B half period, 0 stops
    output logic             pdiv_tick,    // Pulse every fourth clock
    output logic      [31:0] phase_sample, // Detector sample
    output logic             ref_a,        // Reference A
    output logic             ref_b         // Reference B
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_r   = 2'h0;
    logic [3:0] cnt_a_r = 4'h0;
    logic [3:0] cnt_b_r = 4'h0;
    initial begin
        {pdiv_tick, phase_sample, ref_a, ref_b} <= 35'h0;
    end
    // A stopped reference rests low, so it makes no stray rising edge
    always @(posedge hclk) begin
        div_r <= div_r + 2'h1;
        pdiv_tick <= tick_on && div_r == 2'h3;
        phase_sample <= sample_in;
        cnt_a_r <= (cnt_a_r + 4'h1 >= half_a) ? 4'h0 : cnt_a_r + 4'h1;
        cnt_b_r <= (cnt_b_r + 4'h1 >= half_b) ? 4'h0 : cnt_b_r + 4'h1;
        ref_a <= half_a != 4'h0 && (ref_a ^ (cnt_a_r + 4'h1 >= half_a));
        ref_b <= half_b != 4'h0 && (ref_b ^ (cnt_b_r + 4'h1 >= half_b));
    end
endmodule : lrd_far_side

`default_nettype wire

// file: verification/lock_and_reference_loss_detect_test.sv
`default_nettype none

module lock_and_reference_loss_detect_test
    import lrd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize  = LRD_HSIZE_WORD;
    logic [31:0] haddr  = 32'h0, hwdata = 32'h0, sample = 32'h0000_1000;
    logic        tick_on = 1'b0;
    logic [3:0]  half_a = 4'h0, half_b = 4'h0;
    logic [31:0] hrdata, phase_sample;
    logic        hreadyout, hresp, pdiv_tick, ref_a, ref_b, plock, flock;
    logic [3:0]  pins;
    int          mismatches = 0;
    int          comparisons = 0;

    always #5 hclk = ~hclk;

    lrd_top uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pdiv_tick(pdiv_tick), .phase_sample(phase_sample),
        .first_reference_input(ref_a), .second_reference_input(ref_b),
        .multipurpose_status_pins(pins), .phase_lock(plock),
        .frequency_lock(flock)
    );

    lrd_far_side far (
        .hclk(hclk), .tick_on(tick_on), .sample_in(sample), .half_a(half_a),
        .half_b(half_b), .pdiv_tick(pdiv_tick), .phase_sample(phase_sample),
        .ref_a(ref_a), .ref_b(ref_b)
    );

    task results;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Every phase is held until hready is seen high at an edge
    task rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : rdy

    task adr(input logic [7:0] a, input logic w);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy;
        htrans <= 2'h0;
    endtask : adr

    task wr(input logic [7:0] a, input logic [31:0] d);
        adr(a, 1'b1);
        hwdata <= d;
        rdy;
    endtask : wr

    task rdr(input logic [7:0] a, output logic [31:0] d);
        adr(a, 1'b0);
        rdy;
        d = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : rdr

    task chkr(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rdr(a, v);
        chk(v, exp);
    endtask : chkr

    task lk(input logic [1:0] e);
        chk({30'h0, flock, plock}, {30'h0, e});
    endtask : lk

    // Returns two clocks after the n-th tick, so the lock flags have landed
    task tick(input int n);
        repeat (n) begin
            do @(posedge hclk); while (pdiv_tick !== 1'b1);
        end
        repeat (2) @(posedge hclk);
    endtask : tick

    task regs;
        logic [31:0] ex [10];
        ex = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_FFFF,
               32'h0000_FFFF, 32'h0, 32'h0, 32'h0};
        chk({26'h0, pins, flock, plock}, 32'h0);
        for (int i = 0; i < 10; i++) begin
            chkr(8'(4 * i), ex[i]);
        end
        wr(LRD_CTRL_OFS, 32'hFFFF_FFFF);
        chkr(LRD_CTRL_OFS, LRD_CTRL_MASK);
        wr(LRD_CTRL_OFS, 32'h0);
        wr(LRD_PLT_OFS, 32'hFFFF_FFFF);
        chkr(LRD_PLT_OFS, 32'hFFFF_FFFF);
        hsize <= 3'h0;
        wr(LRD_PLT_OFS, 32'h0);
        hsize <= LRD_HSIZE_WORD;
        chkr(LRD_PLT_OFS, 32'hFFFF_FFFF);
        wr(LRD_PINT_OFS, 32'hFFFF_FFFF);
        chkr(LRD_PINT_OFS, 32'h0000_071F);
        wr(LRD_LORA_OFS, 32'hFFFF_FFFF);
        chkr(LRD_LORA_OFS, 32'h0000_FFFF);
        wr(LRD_STAT_OFS, 32'hFFFF_FFFF);
        chkr(LRD_STAT_OFS, 32'h0);
    endtask : regs

    task locks;
        logic [31:0] v;
        wr(LRD_PLT_OFS, 32'h0000_000A);
        wr(LRD_FLT_OFS, 32'h0000_000A);
        wr(LRD_PINT_OFS, 32'h0000_0002);
        wr(LRD_FINT_OFS, 32'h0000_0003);
        sample <= 32'hFFFF_FFF6;
        tick_on <= 1'b1;
        tick(3);
        lk(2'h0);
        tick(1);
        lk(2'h1);
        tick(3);
        lk(2'h1);
        tick(1);
        lk(2'h3);
        rdr(LRD_STAT_OFS, v);
        chk(v & 32'h3, 32'h3);
        sample <= 32'h0000_000B;
        tick(1);
        lk(2'h3);
        tick(1);
        lk(2'h2);
        sample <= 32'hFFFF_FFF6;
        tick(3);
        lk(2'h2);
        tick(1);
        lk(2'h3);
        tick_on <= 1'b0;
    endtask : locks

    task loss;
        logic [31:0] v;
        int          n;
        half_a <= 4'h2;
        wr(LRD_LORA_OFS, 32'h0000_0005);
        wr(LRD_LORB_OFS, 32'h0000_0004);
        wr(LRD_CTRL_OFS, 32'h0000_0653);
        repeat (40) @(posedge hclk);
        chk({28'h0, pins}, 32'h4);
        rdr(LRD_STAT_OFS, v);
        chk(v & 32'hC, 32'h8);
        chkr(LRD_IRQ_OFS, 32'h2);
        half_b <= 4'h2;
        repeat (40) @(posedge hclk);
        chk({28'h0, pins}, 32'h0);
        rdr(LRD_STAT_OFS, v);
        chk(v & 32'hC, 32'h0);
        chkr(LRD_IRQ_OFS, 32'h2);
        wr(LRD_IRQ_OFS, 32'h2);
        chkr(LRD_IRQ_OFS, 32'h0);
        half_a <= 4'h0;
        n = 0;
        while (pins[1] !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, n >= 7 && n <= 17}, 32'h1);
        chkr(LRD_IRQ_OFS, 32'h1);
        wr(LRD_CTRL_OFS, 32'h0000_0031);
        repeat (2) @(posedge hclk);
        chk({28'h0, pins}, 32'h0);
        wr(LRD_CTRL_OFS, 32'h0000_0041);
        repeat (2) @(posedge hclk);
        chk({28'h0, pins}, 32'h1);
        wr(LRD_CTRL_OFS, 32'h0000_0071);
        repeat (2) @(posedge hclk);
        chk({28'h0, pins}, 32'h8);
        wr(LRD_CTRL_OFS, 32'h0);
        repeat (4) @(posedge hclk);
        chk({28'h0, pins}, 32'h0);
        rdr(LRD_STAT_OFS, v);
        chk(v & 32'hC, 32'h0);
    endtask : loss

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        regs;
        locks;
        loss;
        results;
    end

    initial begin
        #100000;
        mismatches++;
        results;
    end
endmodule : lock_and_reference_loss_detect_test

`default_nettype wire
